// ### core/nfq_pkg.sv
// constants and types for the network feature and queue map block
package nfq_pkg;
   // -----------------------------------------------------------
   // feature bit positions
   // -----------------------------------------------------------
   localparam int FEAT_W = 64;
   localparam int F_CSUM = 0;
   localparam int F_GCSUM = 1;
   localparam int F_CGOFF = 2;
   localparam int F_MTU = 3;
   localparam int F_MAC = 5;
   localparam int F_GTSO4 = 7;
   localparam int F_GTSO6 = 8;
   localparam int F_GECN = 9;
   localparam int F_GUFO = 10;
   localparam int F_HTSO4 = 11;
   localparam int F_HTSO6 = 12;
   localparam int F_HECN = 13;
   localparam int F_HUFO = 14;
   localparam int F_MRGBUF = 15;
   localparam int F_STATUS = 16;
   localparam int F_CTRLQ = 17;
   localparam int F_CRXMODE = 18;
   localparam int F_CVLAN = 19;
   localparam int F_ANNOUNCE = 21;
   localparam int F_MQ = 22;
   localparam int F_CMACADDR = 23;
   localparam int F_RSCEXT = 61;
   localparam int F_STANDBY = 62;
   // -----------------------------------------------------------
   // identity, register map and field layout
   // -----------------------------------------------------------
   localparam logic [31:0] DEV_TYPE_RSVD = 32'h0000_0000;
   localparam logic [31:0] DEV_TYPE_NET = 32'h0000_0001;
   localparam int ADDR_W = 8;
   localparam logic [7:0] OFF_TYPE = 8'h00;
   localparam logic [7:0] OFF_DEVF_LO = 8'h04;
   localparam logic [7:0] OFF_DEVF_HI = 8'h08;
   localparam logic [7:0] OFF_DRVF_LO = 8'h0C;
   localparam logic [7:0] OFF_DRVF_HI = 8'h10;
   localparam logic [7:0] OFF_STAT = 8'h14;
   localparam logic [7:0] OFF_NEG_LO = 8'h18;
   localparam logic [7:0] OFF_NEG_HI = 8'h1C;
   localparam logic [7:0] OFF_MAXP = 8'h20;
   localparam logic [7:0] OFF_QSEL = 8'h24;
   localparam logic [7:0] OFF_QINFO = 8'h28;
   localparam logic [7:0] OFF_NUMQ = 8'h2C;
   localparam int STAT_INVALID = 0;
   localparam int STAT_CTRLQ = 1;
   localparam int STAT_MQ = 2;
   localparam int QI_EXISTS = 0;
   localparam int QI_RX = 1;
   localparam int QI_TX = 2;
   localparam int QI_CTRL = 3;
   localparam int QI_PAIR_LSB = 16;
   localparam int PAIR_W = 16;
   localparam int QIDX_W = 17;
   localparam logic [15:0] PAIRS_MIN = 16'h0001;
   localparam logic [15:0] PAIRS_MAX = 16'h8000;
   localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
   // -----------------------------------------------------------
   // bus phase and state
   // -----------------------------------------------------------
   typedef enum logic [1:0]
   {
      PH_IDLE = 2'b01,
      PH_ACK = 2'b10
   } nfq_phase_type;
   typedef struct packed
   {
      nfq_phase_type phase;
      logic [31:0] rdata;
      logic [31:0] drv_lo;
      logic [31:0] drv_hi;
      logic [15:0] max_pairs;
      logic [16:0] qsel;
   } nfq_state_type;
   // byte-lane merge for partial writes
   function automatic logic [31:0] be_merge(input logic [31:0] old_v,
      input logic [31:0] new_v, input logic [3:0] be);
      logic [31:0] r;
      r = old_v;
      for (int i = 0; i < 4; i++)
      begin
         if (be[i])
         begin
            r[8*i +: 8] = new_v[8*i +: 8];
         end
      end
      return r;
   endfunction
endpackage

// ### core/nfq_feat_check.sv
// dependency check that turns an accepted feature set into an enabled set
`timescale 1ns/1ps
module nfq_feat_check
(
   input wire logic [nfq_pkg::FEAT_W-1:0] offered,
   input wire logic [nfq_pkg::FEAT_W-1:0] accepted,
   output logic [nfq_pkg::FEAT_W-1:0] enabled,
   output logic invalid
);
   import nfq_pkg::*;
   logic [FEAT_W-1:0] a;
   logic [FEAT_W-1:0] e;
   always_comb
   begin
      a = accepted & offered;
      e = a;
      e[F_GTSO4] = a[F_GTSO4] & a[F_GCSUM];
      e[F_GTSO6] = a[F_GTSO6] & a[F_GCSUM];
      e[F_GUFO] = a[F_GUFO] & a[F_GCSUM];
      // second stage reads the first so a broken chain drops both
      e[F_GECN] = a[F_GECN] & (e[F_GTSO4] | e[F_GTSO6]);
      e[F_HTSO4] = a[F_HTSO4] & a[F_CSUM];
      e[F_HTSO6] = a[F_HTSO6] & a[F_CSUM];
      e[F_HUFO] = a[F_HUFO] & a[F_CSUM];
      e[F_HECN] = a[F_HECN] & (e[F_HTSO4] | e[F_HTSO6]);
      e[F_RSCEXT] = a[F_RSCEXT] & (e[F_HTSO4] | e[F_HTSO6]);
      e[F_CRXMODE] = a[F_CRXMODE] & a[F_CTRLQ];
      e[F_CVLAN] = a[F_CVLAN] & a[F_CTRLQ];
      e[F_ANNOUNCE] = a[F_ANNOUNCE] & a[F_CTRLQ];
      e[F_MQ] = a[F_MQ] & a[F_CTRLQ];
      e[F_CMACADDR] = a[F_CMACADDR] & a[F_CTRLQ];
      enabled = e;
      invalid = (e != a);
   end
endmodule

// ### core/nfq_queue_map.sv
// queue index decode from the negotiated pair count
`timescale 1ns/1ps
module nfq_queue_map
(
   input wire logic [nfq_pkg::QIDX_W-1:0] sel,
   input wire logic [nfq_pkg::PAIR_W-1:0] max_pairs,
   input wire logic mq_on,
   input wire logic ctrl_on,
   output logic exists,
   output logic is_rx,
   output logic is_tx,
   output logic is_ctrl,
   output logic [nfq_pkg::PAIR_W-1:0] pair_num,
   output logic [nfq_pkg::QIDX_W-1:0] num_q
);
   import nfq_pkg::*;
   logic [PAIR_W-1:0] n;
   logic [QIDX_W-1:0] ctrl_idx;
   logic data_q;
   always_comb
   begin
      n = mq_on ? max_pairs : PAIRS_MIN;
      ctrl_idx = {n, 1'b0};
      data_q = (sel < ctrl_idx);
      is_rx = data_q & ~sel[0];
      is_tx = data_q & sel[0];
      is_ctrl = ctrl_on & (sel == ctrl_idx);
      exists = data_q | is_ctrl;
      pair_num = data_q ? PAIR_W'(sel[QIDX_W-1:1] + 16'h0001) : 16'h0000;
      num_q = QIDX_W'(ctrl_idx + {16'h0000, ctrl_on});
   end
endmodule

// ### core/nfq_top.sv
// feature negotiation and queue map with an avalon register slave
`timescale 1ns/1ps
module nfq_top
#(
   parameter logic [15:0] MAX_PAIRS_RST = 16'h0001
)
(
   input wire logic clk,
   input wire logic reset_n,
   input wire logic [nfq_pkg::ADDR_W-1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest
);
   import nfq_pkg::*;

   // ----------------------------------------------------------------
   // offered feature set
   // ----------------------------------------------------------------
   localparam logic [FEAT_W-1:0] ONE = 64'h1;
   localparam logic [FEAT_W-1:0] OFFER =
      (ONE << F_CSUM) |
      (ONE << F_GCSUM) |
      (ONE << F_CGOFF) |
      (ONE << F_MTU) |
      (ONE << F_MAC) |
      (ONE << F_GTSO4) | (ONE << F_GTSO6) |
      (ONE << F_GECN) | (ONE << F_GUFO) |
      (ONE << F_HTSO4) | (ONE << F_HTSO6) |
      (ONE << F_HECN) | (ONE << F_HUFO) |
      (ONE << F_MRGBUF) | (ONE << F_STATUS) |
      (ONE << F_CTRLQ) | (ONE << F_CRXMODE) |
      (ONE << F_CVLAN) |
      (ONE << F_ANNOUNCE) | (ONE << F_CMACADDR) |
      (ONE << F_MQ) |
      (ONE << F_RSCEXT) |
      (ONE << F_STANDBY);

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   nfq_state_type st_reg;
   nfq_state_type st_next;
   logic [FEAT_W-1:0] enabled;
   logic invalid;
   logic q_exists;
   logic q_rx;
   logic q_tx;
   logic q_ctrl;
   logic [PAIR_W-1:0] q_pair;
   logic [QIDX_W-1:0] num_q;
   logic req;
   logic [31:0] rword;
   logic [31:0] wmax;

   // ----------------------------------------------------------------
   // submodules
   // ----------------------------------------------------------------
   nfq_feat_check u_check
   (
      .offered(OFFER),
      .accepted({st_reg.drv_hi, st_reg.drv_lo}),
      .enabled(enabled),
      .invalid(invalid)
   );

   nfq_queue_map u_qmap
   (
      .sel(st_reg.qsel),
      .max_pairs(st_reg.max_pairs),
      .mq_on(enabled[F_MQ]),
      .ctrl_on(enabled[F_CTRLQ]),
      .exists(q_exists),
      .is_rx(q_rx),
      .is_tx(q_tx),
      .is_ctrl(q_ctrl),
      .pair_num(q_pair),
      .num_q(num_q)
   );

   // ----------------------------------------------------------------
   // bus slave
   // ----------------------------------------------------------------
   // one wait cycle per access keeps readdata a plain flip-flop
   assign req = avs_read | avs_write;
   assign avs_waitrequest = req & (st_reg.phase != PH_ACK);
   assign avs_readdata = st_reg.rdata;

   always_comb
   begin
      case (avs_address)
         OFF_TYPE: rword = DEV_TYPE_NET;
         OFF_DEVF_LO: rword = OFFER[31:0];
         OFF_DEVF_HI: rword = OFFER[63:32];
         OFF_DRVF_LO: rword = st_reg.drv_lo;
         OFF_DRVF_HI: rword = st_reg.drv_hi;
         OFF_STAT:
         begin
            rword = WORD_ZERO;
            rword[STAT_INVALID] = invalid;
            rword[STAT_CTRLQ] = enabled[F_CTRLQ];
            rword[STAT_MQ] = enabled[F_MQ];
         end
         OFF_NEG_LO: rword = enabled[31:0];
         OFF_NEG_HI: rword = enabled[63:32];
         OFF_MAXP: rword = {16'h0000, st_reg.max_pairs};
         OFF_QSEL: rword = {15'h0000, st_reg.qsel};
         OFF_QINFO:
         begin
            rword = WORD_ZERO;
            rword[QI_EXISTS] = q_exists;
            rword[QI_RX] = q_rx;
            rword[QI_TX] = q_tx;
            rword[QI_CTRL] = q_ctrl;
            rword[QI_PAIR_LSB +: PAIR_W] = q_pair;
         end
         OFF_NUMQ: rword = {15'h0000, num_q};
         default: rword = WORD_ZERO;
      endcase
   end

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb
   begin
      st_next = st_reg;
      wmax = be_merge({16'h0000, st_reg.max_pairs}, avs_writedata,
         avs_byteenable);
      case (st_reg.phase)
         PH_IDLE:
         begin
            if (req)
            begin
               st_next.phase = PH_ACK;
               if (avs_read)
               begin
                  st_next.rdata = rword;
               end
               else
               begin
                  case (avs_address)
                     OFF_DRVF_LO:
                        st_next.drv_lo = be_merge(st_reg.drv_lo,
                           avs_writedata, avs_byteenable);
                     OFF_DRVF_HI:
                        st_next.drv_hi = be_merge(st_reg.drv_hi,
                           avs_writedata, avs_byteenable);
                     OFF_MAXP:
                     begin
                        // pair count clamped to the legal window
                        if (wmax[15:0] == 16'h0000)
                        begin
                           st_next.max_pairs = PAIRS_MIN;
                        end
                        else if (wmax[15:0] > PAIRS_MAX)
                        begin
                           st_next.max_pairs = PAIRS_MAX;
                        end
                        else
                        begin
                           st_next.max_pairs = wmax[15:0];
                        end
                     end
                     OFF_QSEL:
                        st_next.qsel = QIDX_W'(be_merge(
                           {15'h0000, st_reg.qsel}, avs_writedata,
                           avs_byteenable));
                     default:
                        st_next.phase = PH_ACK;
                  endcase
               end
            end
         end
         PH_ACK:
         begin
            st_next.phase = PH_IDLE;
         end
         default:
         begin
            st_next.phase = PH_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         st_reg.phase <= PH_IDLE;
         st_reg.rdata <= WORD_ZERO;
         st_reg.drv_lo <= WORD_ZERO;
         st_reg.drv_hi <= WORD_ZERO;
         st_reg.max_pairs <= MAX_PAIRS_RST;
         st_reg.qsel <= 17'h00000;
      end
      else
      begin
         st_reg <= st_next;
      end
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   property p_type_read;
      @(posedge clk) disable iff (!reset_n)
      (avs_read && !avs_waitrequest && $past(avs_address) == OFF_TYPE
         && $past(st_reg.phase) == PH_IDLE)
         |-> (avs_readdata == DEV_TYPE_NET)
         && (avs_readdata != DEV_TYPE_RSVD);
   endproperty
   a_type_read: assert property (p_type_read)
      else $error("type code read wrong");

   property p_rx_even;
      @(posedge clk) disable iff (!reset_n)
      q_rx |-> !st_reg.qsel[0]
         && (st_reg.qsel < {(enabled[F_MQ] ? st_reg.max_pairs
            : PAIRS_MIN), 1'b0});
   endproperty
   a_rx_even: assert property (p_rx_even)
      else $error("receive queue at wrong index");

   property p_ctrl_only;
      @(posedge clk) disable iff (!reset_n)
      q_ctrl |-> enabled[F_CTRLQ] && st_reg.qsel == num_q - 17'h00001;
   endproperty
   a_ctrl_only: assert property (p_ctrl_only)
      else $error("control queue without its feature");

   property p_guest_csum;
      @(posedge clk) disable iff (!reset_n)
      (enabled[F_GTSO4] || enabled[F_GTSO6] || enabled[F_GUFO])
         |-> enabled[F_GCSUM];
   endproperty
   a_guest_csum: assert property (p_guest_csum)
      else $error("guest offload without guest checksum");

   property p_guest_ecn;
      @(posedge clk) disable iff (!reset_n)
      enabled[F_GECN] |-> (enabled[F_GTSO4] || enabled[F_GTSO6]);
   endproperty
   a_guest_ecn: assert property (p_guest_ecn)
      else $error("guest congestion bit without tcp offload");

   property p_host_csum;
      @(posedge clk) disable iff (!reset_n)
      (enabled[F_HTSO4] || enabled[F_HTSO6] || enabled[F_HUFO])
         |-> enabled[F_CSUM];
   endproperty
   a_host_csum: assert property (p_host_csum)
      else $error("host offload without checksum");

   property p_host_ecn;
      @(posedge clk) disable iff (!reset_n)
      (enabled[F_HECN] || enabled[F_RSCEXT])
         |-> (enabled[F_HTSO4] || enabled[F_HTSO6]);
   endproperty
   a_host_ecn: assert property (p_host_ecn)
      else $error("host congestion without tcp offload");

   property p_ctrl_deps;
      @(posedge clk) disable iff (!reset_n)
      (enabled[F_CRXMODE] || enabled[F_CVLAN] || enabled[F_ANNOUNCE]
         || enabled[F_MQ] || enabled[F_CMACADDR]) |-> enabled[F_CTRLQ];
   endproperty
   a_ctrl_deps: assert property (p_ctrl_deps)
      else $error("control feature without control queue");

   property p_flag_bad;
      @(posedge clk) disable iff (!reset_n)
      (st_reg.drv_lo[F_GTSO4] && !st_reg.drv_lo[F_GCSUM])
         |-> invalid && !enabled[F_GTSO4];
   endproperty
   a_flag_bad: assert property (p_flag_bad)
      else $error("broken set not flagged");

   property p_pair_index;
      @(posedge clk) disable iff (!reset_n)
      (q_rx || q_tx) |-> {q_pair - 16'h0001, q_tx} == st_reg.qsel;
   endproperty
   a_pair_index: assert property (p_pair_index)
      else $error("data queue index does not match its pair");

   property p_ctrl_index;
      @(posedge clk) disable iff (!reset_n)
      (enabled[F_CTRLQ] && st_reg.qsel ==
         {(enabled[F_MQ] ? st_reg.max_pairs : PAIRS_MIN), 1'b0})
         |-> q_ctrl && q_exists && q_pair == 16'h0000;
   endproperty
   a_ctrl_index: assert property (p_ctrl_index)
      else $error("control queue missing at its index");

   property p_no_ctrl;
      @(posedge clk) disable iff (!reset_n)
      !enabled[F_CTRLQ] |-> !q_ctrl && !num_q[0];
   endproperty
   a_no_ctrl: assert property (p_no_ctrl)
      else $error("control queue present without its feature");

   property p_pairs_legal;
      @(posedge clk) disable iff (!reset_n)
      (st_reg.max_pairs >= PAIRS_MIN) && (st_reg.max_pairs <= PAIRS_MAX);
   endproperty
   a_pairs_legal: assert property (p_pairs_legal)
      else $error("pair count outside its legal window");

   property p_mq_flag;
      @(posedge clk) disable iff (!reset_n)
      (st_reg.drv_lo[F_MQ] && !st_reg.drv_lo[F_CTRLQ])
         |-> invalid && !enabled[F_MQ] && num_q == 17'h00002;
   endproperty
   a_mq_flag: assert property (p_mq_flag)
      else $error("multiqueue kept without control queue");

   property p_en_subset;
      @(posedge clk) disable iff (!reset_n)
      (enabled & ~({st_reg.drv_hi, st_reg.drv_lo} & OFFER)) == 64'h0;
   endproperty
   a_en_subset: assert property (p_en_subset)
      else $error("feature enabled that was not accepted and offered");

endmodule

// ### test/nfq_drv_model.sv
// guest driver model: avalon master that issues register accesses
`timescale 1ns/1ps
module nfq_drv_model
(
   input wire logic clk,
   output logic [nfq_pkg::ADDR_W-1:0] avs_address,
   output logic avs_read,
   output logic avs_write,
   output logic [31:0] avs_writedata,
   output logic [3:0] avs_byteenable,
   input wire logic avs_waitrequest
);
   import nfq_pkg::*;
   initial
   begin
      avs_address = 8'h00;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_writedata = 32'h0;
      avs_byteenable = 4'h0;
   end
   // -----------------------------------------------------------
   // one bus cycle, held until waitrequest is seen low
   // -----------------------------------------------------------
   task automatic acc(input logic wr, input logic [7:0] a,
      input logic [31:0] d, input logic [3:0] be);
      avs_address <= a;
      avs_writedata <= d;
      avs_byteenable <= be;
      avs_read <= !wr;
      avs_write <= wr;
      @(posedge clk);
      while (avs_waitrequest !== 1'b0)
         @(posedge clk);
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      // released address and data show inverted values, never the stale ones; byteenable keeps its value
      avs_address <= ~a;
      avs_writedata <= ~d;
      @(posedge clk);
   endtask
endmodule

// ### test/tb_net_feature_queue_map.sv
// self-checking bench for the feature and queue map block
`timescale 1ns/1ps
module tb_net_feature_queue_map;
   import nfq_pkg::*;
   logic clk;
   logic reset_n;
   logic [7:0] avs_address;
   logic avs_read;
   logic avs_write;
   logic [31:0] avs_writedata;
   logic [3:0] avs_byteenable;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   int err_count;
   int checks_done;
   int cyc;
   logic [31:0] exp_q[$];
   logic [31:0] lfsr;
   logic [63:0] offered;
   int fbits[23] = '{F_CSUM, F_GCSUM, F_CGOFF, F_MTU, F_MAC, F_GTSO4,
      F_GTSO6, F_GECN, F_GUFO, F_HTSO4, F_HTSO6, F_HECN, F_HUFO, F_MRGBUF,
      F_STATUS, F_CTRLQ, F_CRXMODE, F_CVLAN, F_ANNOUNCE, F_MQ, F_CMACADDR,
      F_RSCEXT, F_STANDBY};
   nfq_top dut_u
   (
      .clk(clk),
      .reset_n(reset_n),
      .avs_address(avs_address),
      .avs_read(avs_read),
      .avs_write(avs_write),
      .avs_writedata(avs_writedata),
      .avs_byteenable(avs_byteenable),
      .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest)
   );
   nfq_drv_model drv_u
   (
      .clk(clk),
      .avs_address(avs_address),
      .avs_read(avs_read),
      .avs_write(avs_write),
      .avs_writedata(avs_writedata),
      .avs_byteenable(avs_byteenable),
      .avs_waitrequest(avs_waitrequest)
   );
   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // -----------------------------------------------------------
   // reference of the dependency check and queue layout
   // -----------------------------------------------------------
   function automatic logic [63:0] exp_en(input logic [63:0] a);
      logic [63:0] e;
      e = a & offered;
      if (!e[F_GCSUM])
      begin
         e[F_GTSO4] = 1'b0;
         e[F_GTSO6] = 1'b0;
         e[F_GUFO] = 1'b0;
      end
      if (!e[F_GTSO4] && !e[F_GTSO6])
         e[F_GECN] = 1'b0;
      if (!e[F_CSUM])
      begin
         e[F_HTSO4] = 1'b0;
         e[F_HTSO6] = 1'b0;
         e[F_HUFO] = 1'b0;
      end
      if (!e[F_HTSO4] && !e[F_HTSO6])
      begin
         e[F_HECN] = 1'b0;
         e[F_RSCEXT] = 1'b0;
      end
      if (!e[F_CTRLQ])
      begin
         e[F_CRXMODE] = 1'b0;
         e[F_CVLAN] = 1'b0;
         e[F_ANNOUNCE] = 1'b0;
         e[F_MQ] = 1'b0;
         e[F_CMACADDR] = 1'b0;
      end
      return e;
   endfunction
   function automatic logic [31:0] qinfo(input int q, input int n,
      input logic c);
      logic [31:0] r;
      r = 32'h0;
      if (q < 2 * n)
      begin
         r[QI_EXISTS] = 1'b1;
         r[QI_RX] = (q % 2 == 0);
         r[QI_TX] = (q % 2 == 1);
         r[QI_PAIR_LSB +: 16] = 16'(q / 2 + 1);
      end
      else if (q == 2 * n && c)
      begin
         r[QI_EXISTS] = 1'b1;
         r[QI_CTRL] = 1'b1;
      end
      return r;
   endfunction
   function automatic logic [31:0] lfsr_next(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction
   // -----------------------------------------------------------
   // checking and closing
   // -----------------------------------------------------------
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      checks_done++;
      if (s !== e)
      begin
         err_count++;
         $display("[FAIL] %0t read 0x%08h expected 0x%08h", $time, s, e);
      end
   endtask
   task automatic wrap_up();
      $display("errors %0d checks %0d", err_count, checks_done);
      if (err_count == 0 && checks_done > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   // a read result is compared against the oldest note
   always @(posedge clk)
   begin
      if (avs_read === 1'b1 && avs_waitrequest === 1'b0)
      begin
         if (exp_q.size() == 0)
            chk(avs_readdata, 32'hXXXX_XXXX);
         else
            chk(avs_readdata, exp_q.pop_front());
      end
   end
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         err_count++;
         wrap_up();
      end
   end
   task automatic rx(input logic [7:0] a, input logic [31:0] e);
      exp_q.push_back(e);
      drv_u.acc(1'b0, a, 32'h0, 4'hF);
   endtask
   task automatic wx(input logic [7:0] a, input logic [31:0] d);
      drv_u.acc(1'b1, a, d, 4'hF);
   endtask
   task automatic negotiate(input logic [63:0] a, input logic [15:0] mp);
      logic [63:0] e;
      logic c;
      logic inv;
      int n;
      int qs[6];
      e = exp_en(a);
      c = e[F_CTRLQ];
      inv = (e != (a & offered));
      n = e[F_MQ] ? int'(mp) : 1;
      qs = '{0, 1, 2 * n - 2, 2 * n - 1, 2 * n, 2 * n + 1};
      wx(OFF_MAXP, {16'h0, mp});
      wx(OFF_DRVF_LO, a[31:0]);
      wx(OFF_DRVF_HI, a[63:32]);
      rx(OFF_DRVF_HI, a[63:32]);
      rx(OFF_NEG_LO, e[31:0]);
      rx(OFF_NEG_HI, e[63:32]);
      rx(OFF_STAT, {29'h0, e[F_MQ], c, inv});
      rx(OFF_NUMQ, 32'(2 * n + int'(c)));
      foreach (qs[i])
      begin
         wx(OFF_QSEL, 32'(qs[i]));
         rx(OFF_QINFO, qinfo(qs[i], n, c));
      end
   endtask
   // -----------------------------------------------------------
   // main sequence
   // -----------------------------------------------------------
   initial
   begin
      reset_n = 1'b0;
      lfsr = 32'hDFED;
      offered = 64'h0;
      foreach (fbits[i])
         offered[fbits[i]] = 1'b1;
      repeat (5) @(posedge clk);
      reset_n <= 1'b1;
      @(posedge clk);
      rx(OFF_DRVF_LO, 32'h0);
      rx(OFF_NEG_LO, 32'h0);
      rx(OFF_NUMQ, 32'h2);
      rx(OFF_MAXP, 32'h1);
      rx(OFF_TYPE, DEV_TYPE_NET);
      wx(OFF_TYPE, DEV_TYPE_RSVD);
      rx(OFF_TYPE, DEV_TYPE_NET);
      rx(8'h40, 32'h0);
      rx(OFF_DEVF_LO, offered[31:0]);
      rx(OFF_DEVF_LO, offered[31:0]);
      rx(OFF_DEVF_HI, offered[63:32]);
      wx(OFF_MAXP, 32'h0);
      rx(OFF_MAXP, 32'h1);
      wx(OFF_MAXP, 32'hFFFF);
      rx(OFF_MAXP, 32'h8000);
      // one byte lane only: the upper byte changes, the lower stays
      drv_u.acc(1'b1, OFF_MAXP, 32'h0000_0300, 4'h2);
      rx(OFF_MAXP, 32'h0300);
      wx(OFF_QSEL, 32'h0001_2345);
      rx(OFF_QSEL, 32'h0001_2345);
      negotiate(offered, 16'h0004);
      negotiate(offered, 16'h8000);
      negotiate(offered & ~(64'h1 << F_CTRLQ), 16'h0004);
      negotiate(offered & ~(64'h1 << F_GCSUM), 16'h0002);
      negotiate(offered & ~(64'h3 << F_HTSO4), 16'h0002);
      negotiate(offered & ~(64'h1 << F_CSUM), 16'h0002);
      negotiate(~64'h0, 16'h0003);
      repeat (16)
      begin
         lfsr = lfsr_next(lfsr);
         offered[63:0] = offered;
         negotiate({lfsr, lfsr_next(lfsr)}, 16'(lfsr[2:0]) + 16'h1);
         lfsr = lfsr_next(lfsr);
      end
      if (exp_q.size() != 0)
         err_count++;
      wrap_up();
   end
endmodule
